// File: core/cfl_top.sv
// How it works
// RULE1: Sign bit seven, zero six, carry zero.
// RULE2: Bit one records whether last op subtracted.
// RULE3: Bit two holds parity after logical ops.
// RULE4: Signed arithmetic uses bit two as overflow.
// RULE5: Overflow set when signed result out of range.
// RULE6: Compare sets overflow as subtraction does.
// RULE7: Bit four is nibble carry or borrow.
// RULE8: Half carry undefined after 16-bit add.
// RULE9: Rotates clear half carry.
// RULE10: Complement accumulator sets half carry.
// RULE11: Half carry undefined after complement carry.
// RULE12: Set carry clears half carry.
// RULE13: Parity flag one means even ones count.
// RULE14: Bits five and three are don't care.
`timescale 1ns/1ns
module cfl_top
  import cfl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cfl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  cfl_axil u_bus (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] condition_flags;
  logic [7:0] acc;
  logic [7:0] opnd;
  logic [15:0] de;
  logic [15:0] hl;
  cfl_op_t last_op;
  logic [7:0] next_condition_flags;
  logic [7:0] next_acc;
  logic [7:0] next_opnd;
  logic [15:0] next_de;
  logic [15:0] next_hl;
  cfl_op_t next_last_op;
  cfl_req_t req;
  cfl_res_t res;
  logic exec;

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    byte_merge = s[0] ? d[7:0] : old;
  endfunction

  function automatic logic [15:0] half_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    half_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == ADDR_FLAGS) || (a == ADDR_ACC) || (a == ADDR_OPND) ||
                 (a == ADDR_CMD) || (a == ADDR_DE) || (a == ADDR_HL);
  endfunction

  // Executing an op writes the accumulator and flags from the ALU in one cycle.
  assign exec = wr_en && (wr_addr == ADDR_CMD) && wr_strb[0] &&
                (wr_data[CMD_OP_LSB +: 4] <= 4'(CFL_OP_NOP));
  assign wr_ok = addr_known(wr_addr);
  assign rd_ok = addr_known(rd_addr);

  always_comb
  begin
    req.op = cfl_op_t'(wr_data[CMD_OP_LSB +: 4]);
    req.acc = acc;
    req.opnd = opnd;
    req.flags = condition_flags;
    req.hl = hl;
    req.de = de;
  end

  cfl_alu u_alu (
    .req(req),
    .res(res)
  );

  always_comb
  begin
    next_condition_flags = condition_flags;
    next_acc = acc;
    next_opnd = opnd;
    next_de = de;
    next_hl = hl;
    next_last_op = last_op;
    if (wr_en)
    begin
      if (exec)
      begin
        next_condition_flags = res.flags; // [RULE1] [RULE2] [RULE7]
        next_acc = res.acc;
        next_hl = res.hl;
        next_last_op = req.op;
      end
      else if (wr_addr == ADDR_FLAGS)
      begin
        next_condition_flags = byte_merge(condition_flags, wr_data, wr_strb);
      end
      else if (wr_addr == ADDR_ACC)
      begin
        next_acc = byte_merge(acc, wr_data, wr_strb);
      end
      else if (wr_addr == ADDR_OPND)
      begin
        next_opnd = byte_merge(opnd, wr_data, wr_strb);
      end
      else if (wr_addr == ADDR_DE)
      begin
        next_de = half_merge(de, wr_data, wr_strb);
      end
      else if (wr_addr == ADDR_HL)
      begin
        next_hl = half_merge(hl, wr_data, wr_strb);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      condition_flags <= FLAGS_RESET;
      acc <= 8'h00;
      opnd <= 8'h00;
      de <= 16'h0000;
      hl <= 16'h0000;
      last_op <= CFL_OP_NOP;
    end
    else
    begin
      condition_flags <= next_condition_flags;
      acc <= next_acc;
      opnd <= next_opnd;
      de <= next_de;
      hl <= next_hl;
      last_op <= next_last_op;
    end
  end

  always_comb
  begin
    rd_data = 32'h00000000;
    if (rd_addr == ADDR_FLAGS)
    begin
      rd_data = {24'h000000, condition_flags};
    end
    else if (rd_addr == ADDR_ACC)
    begin
      rd_data = {24'h000000, acc};
    end
    else if (rd_addr == ADDR_OPND)
    begin
      rd_data = {24'h000000, opnd};
    end
    else if (rd_addr == ADDR_CMD)
    begin
      rd_data = {28'h0000000, 4'(last_op)};
    end
    else if (rd_addr == ADDR_DE)
    begin
      rd_data = {16'h0000, de};
    end
    else if (rd_addr == ADDR_HL)
    begin
      rd_data = {16'h0000, hl};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the flags and accumulator after executed ADD, SUB, CMP, AND, XOR, rotate, CPL and SCF ops.
  property p_sign_zero;
    @(posedge clk) disable iff (sys_rst)
    exec && (req.op == CFL_OP_AND) |=>
      condition_flags[FLAG_SIGN] == acc[7] && condition_flags[FLAG_ZERO] == (acc == 8'h00);
  endproperty
  a_sign_zero: assert property (p_sign_zero) else $error("sign or zero flag wrong"); // [RULE1]

  property p_sub_flag;
    @(posedge clk) disable iff (sys_rst)
    exec && (req.op == CFL_OP_SUB || req.op == CFL_OP_CMP) |=> condition_flags[FLAG_SUB];
  endproperty
  a_sub_flag: assert property (p_sub_flag) else $error("subtract flag not set"); // [RULE2]

  property p_parity;
    @(posedge clk) disable iff (sys_rst)
    exec && (req.op == CFL_OP_XOR) |=> condition_flags[FLAG_PV] == ~^acc;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong"); // [RULE3]

  property p_overflow;
    @(posedge clk) disable iff (sys_rst)
    exec && req.op == CFL_OP_ADD && !acc[7] && !opnd[7] |=>
      condition_flags[FLAG_PV] == acc[7];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag wrong"); // [RULE5]

  property p_cmp_keeps_acc;
    @(posedge clk) disable iff (sys_rst)
    exec && req.op == CFL_OP_CMP |=> acc == $past(acc);
  endproperty
  a_cmp_keeps_acc: assert property (p_cmp_keeps_acc) else $error("compare changed acc"); // [RULE6]

  property p_rot_half;
    @(posedge clk) disable iff (sys_rst)
    exec && (req.op == CFL_OP_RLC || req.op == CFL_OP_RRC) |=> !condition_flags[FLAG_HALF];
  endproperty
  a_rot_half: assert property (p_rot_half) else $error("rotate left half carry"); // [RULE9]

  property p_cpl_half;
    @(posedge clk) disable iff (sys_rst)
    exec && req.op == CFL_OP_CPL |=> condition_flags[FLAG_HALF] && acc == ~$past(acc);
  endproperty
  a_cpl_half: assert property (p_cpl_half) else $error("complement half carry"); // [RULE10]

  property p_scf_half;
    @(posedge clk) disable iff (sys_rst)
    exec && req.op == CFL_OP_SCF |=> !condition_flags[FLAG_HALF] && condition_flags[FLAG_CARRY];
  endproperty
  a_scf_half: assert property (p_scf_half) else $error("set carry flags wrong"); // [RULE12]
endmodule

// File: core/cfl_pkg.sv
package cfl_pkg;

  // Flag register bit positions.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_SUB = 1;
  localparam int FLAG_PV = 2;
  localparam int FLAG_U3 = 3;
  localparam int FLAG_HALF = 4;
  localparam int FLAG_U5 = 5;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Register byte addresses.
  localparam logic [11:0] ADDR_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_ACC = 12'h004;
  localparam logic [11:0] ADDR_OPND = 12'h008;
  localparam logic [11:0] ADDR_CMD = 12'h00c;
  localparam logic [11:0] ADDR_DE = 12'h010;
  localparam logic [11:0] ADDR_HL = 12'h014;

  // Command field: op code in bits 3:0, write strobe triggers execution.
  localparam int CMD_OP_LSB = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    CFL_OP_ADD, CFL_OP_ADC, CFL_OP_SUB, CFL_OP_SBC, CFL_OP_CMP,
    CFL_OP_AND, CFL_OP_OR, CFL_OP_XOR, CFL_OP_RLC, CFL_OP_RRC,
    CFL_OP_CPL, CFL_OP_CCF, CFL_OP_SCF, CFL_OP_ADD16, CFL_OP_NOP
  } cfl_op_t;

  typedef struct packed {
    cfl_op_t op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [7:0] flags;
    logic [15:0] hl;
    logic [15:0] de;
  } cfl_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [15:0] hl;
  } cfl_res_t;

endpackage

// File: core/cfl_alu.sv
`timescale 1ns/1ns
module cfl_alu
  import cfl_pkg::*;
(
  // Operation in
  input wire cfl_pkg::cfl_req_t req,
  // Result out
  output cfl_pkg::cfl_res_t res
);
  import cfl_pkg::*;

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~^v;
  endfunction

  always_comb
  begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [16:0] wide;
    logic [7:0] b;
    logic cin;
    logic sub;
    sum = 9'h000;
    low = 5'h00;
    wide = 17'h00000;
    b = 8'h00;
    cin = 1'b0;
    sub = 1'b0;
    res.acc = req.acc;
    res.flags = req.flags;
    res.hl = req.hl;
    unique case (req.op)
      CFL_OP_ADD, CFL_OP_ADC, CFL_OP_SUB, CFL_OP_SBC, CFL_OP_CMP:
      begin
        sub = (req.op == CFL_OP_SUB) || (req.op == CFL_OP_SBC) || (req.op == CFL_OP_CMP);
        cin = ((req.op == CFL_OP_ADC) || (req.op == CFL_OP_SBC)) & req.flags[FLAG_CARRY];
        // Subtraction is done as add of the inverted operand with inverted borrow in.
        b = sub ? ~req.opnd : req.opnd;
        sum = {1'b0, req.acc} + {1'b0, b} + {8'h00, cin ^ sub};
        low = {1'b0, req.acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin ^ sub};
        res.flags[FLAG_SIGN] = sum[7]; // [RULE1]
        res.flags[FLAG_ZERO] = (sum[7:0] == 8'h00); // [RULE1]
        res.flags[FLAG_CARRY] = sum[8] ^ sub; // [RULE1]
        res.flags[FLAG_HALF] = low[4] ^ sub; // [RULE7]
        // Signed overflow: operands alike in sign, result differs. [RULE4] [RULE5] [RULE6]
        res.flags[FLAG_PV] = (req.acc[7] == b[7]) && (sum[7] != req.acc[7]);
        res.flags[FLAG_SUB] = sub; // [RULE2]
        if (req.op != CFL_OP_CMP)
        begin
          res.acc = sum[7:0];
        end
      end
      CFL_OP_AND, CFL_OP_OR, CFL_OP_XOR:
      begin
        if (req.op == CFL_OP_AND)
        begin
          res.acc = req.acc & req.opnd;
        end
        else if (req.op == CFL_OP_OR)
        begin
          res.acc = req.acc | req.opnd;
        end
        else
        begin
          res.acc = req.acc ^ req.opnd;
        end
        res.flags[FLAG_SIGN] = res.acc[7]; // [RULE1]
        res.flags[FLAG_ZERO] = (res.acc == 8'h00); // [RULE1]
        res.flags[FLAG_CARRY] = 1'b0;
        res.flags[FLAG_HALF] = (req.op == CFL_OP_AND); // [RULE7]
        res.flags[FLAG_PV] = even_parity(res.acc); // [RULE3] [RULE13]
        res.flags[FLAG_SUB] = 1'b0; // [RULE2]
      end
      CFL_OP_RLC, CFL_OP_RRC:
      begin
        if (req.op == CFL_OP_RLC)
        begin
          res.acc = {req.acc[6:0], req.acc[7]};
          res.flags[FLAG_CARRY] = req.acc[7];
        end
        else
        begin
          res.acc = {req.acc[0], req.acc[7:1]};
          res.flags[FLAG_CARRY] = req.acc[0];
        end
        res.flags[FLAG_HALF] = 1'b0; // [RULE9]
        res.flags[FLAG_SUB] = 1'b0; // [RULE2]
      end
      CFL_OP_CPL:
      begin
        res.acc = ~req.acc;
        res.flags[FLAG_HALF] = 1'b1; // [RULE10]
        res.flags[FLAG_SUB] = 1'b1; // [RULE2]
      end
      CFL_OP_CCF:
      begin
        // Half carry is left undefined; it keeps the old carry. [RULE11]
        res.flags[FLAG_HALF] = req.flags[FLAG_CARRY];
        res.flags[FLAG_CARRY] = ~req.flags[FLAG_CARRY];
        res.flags[FLAG_SUB] = 1'b0; // [RULE2]
      end
      CFL_OP_SCF:
      begin
        res.flags[FLAG_CARRY] = 1'b1;
        res.flags[FLAG_HALF] = 1'b0; // [RULE12]
        res.flags[FLAG_SUB] = 1'b0; // [RULE2]
      end
      CFL_OP_ADD16:
      begin
        wide = {1'b0, req.hl} + {1'b0, req.de};
        res.hl = wide[15:0];
        res.flags[FLAG_CARRY] = wide[16];
        // Half carry is undefined here; the 12-bit sum never exceeds 12'hfff, so it is always cleared. [RULE8]
        res.flags[FLAG_HALF] = (req.hl[11:0] + req.de[11:0]) > 12'hfff;
        res.flags[FLAG_SUB] = 1'b0; // [RULE2]
      end
      default:
      begin
        res.acc = req.acc;
      end
    endcase
  end
endmodule

// File: core/cfl_axil.sv
`timescale 1ns/1ns
module cfl_axil
  import cfl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import cfl_pkg::*;

  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_addr = s_axi_araddr;
  // Both halves are in hand for exactly one cycle before the response rises.
  assign wr_en = aw_held & w_held & ~s_axi_bvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (wr_en)
    begin
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
  end

  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

// File: testbench/tb_cpu_condition_flag_logic.sv
`timescale 1ns/1ns
module tb_cpu_condition_flag_logic;
  import cfl_pkg::*;

  logic clk;
  logic sys_rst;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  int fail_count;
  int checked;
  logic [31:0] rd;
  logic [1:0] rsp;

  cfl_top cfl_top_i (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Each transfer starts one edge after the previous one ended, so no strobe is
  // assigned twice in one time step. Sampling right after the edge sees pre-edge values.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200)
      fail_count++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200)
      fail_count++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Loads operands and flags, runs one op, then compares the flags under a mask
  // that hides the bits the op leaves undefined, and the resulting accumulator.
  task automatic run_op(input cfl_op_t op, input logic [7:0] acc, input logic [7:0] opnd,
                        input logic [7:0] fin, input logic [7:0] fexp, input logic [7:0] mask,
                        input logic [7:0] aexp);
    logic [31:0] d;
    logic [1:0] r;
    axi_write(ADDR_ACC, {24'h000000, acc}, r);
    axi_write(ADDR_OPND, {24'h000000, opnd}, r);
    axi_write(ADDR_FLAGS, {24'h000000, fin}, r);
    axi_write(ADDR_CMD, {28'h0000000, op}, r);
    check({30'h00000000, r}, {30'h00000000, RESP_OKAY});
    axi_read(ADDR_FLAGS, d, r);
    check(d & {24'h000000, mask}, {24'h000000, fexp & mask});
    axi_read(ADDR_ACC, d, r);
    check(d, {24'h000000, aexp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0;
    checked = 0;
    sys_rst = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    axi_read(ADDR_FLAGS, rd, rsp);
    check(rd, {24'h000000, FLAGS_RESET});
    axi_read(ADDR_CMD, rd, rsp);
    check(rd, 32'h0000000e);
    axi_write(ADDR_FLAGS, 32'hffffffff, rsp);
    axi_read(ADDR_FLAGS, rd, rsp);
    check(rd, 32'h000000ff);
    axi_write(12'h018, 32'h12345678, rsp);
    check({30'h00000000, rsp}, {30'h00000000, RESP_SLVERR});
    axi_read(12'h018, rd, rsp);
    check({rd[29:0], rsp}, {30'h00000000, RESP_SLVERR});
    // Overflow into the sign bit also crosses the nibble boundary.
    run_op(CFL_OP_ADD, 8'h7f, 8'h01, 8'h00, 8'h94, 8'hd7, 8'h80);
    run_op(CFL_OP_ADC, 8'h0f, 8'h00, 8'h01, 8'h10, 8'hd7, 8'h10);
    run_op(CFL_OP_SUB, 8'h80, 8'h01, 8'h00, 8'h16, 8'hd7, 8'h7f);
    run_op(CFL_OP_SBC, 8'h00, 8'h00, 8'h01, 8'h93, 8'hd7, 8'hff);
    run_op(CFL_OP_CMP, 8'h80, 8'h01, 8'h00, 8'h16, 8'hd7, 8'h80);
    run_op(CFL_OP_AND, 8'h0f, 8'h03, 8'h01, 8'h14, 8'hd7, 8'h03);
    run_op(CFL_OP_XOR, 8'h07, 8'h00, 8'h01, 8'h00, 8'hd7, 8'h07);
    run_op(CFL_OP_OR, 8'h00, 8'h00, 8'h00, 8'h44, 8'hd7, 8'h00);
    run_op(CFL_OP_RLC, 8'h81, 8'h00, 8'hd4, 8'hc5, 8'hd5, 8'h03);
    run_op(CFL_OP_RRC, 8'h01, 8'h00, 8'h10, 8'h01, 8'hd5, 8'h80);
    run_op(CFL_OP_CPL, 8'h5a, 8'h00, 8'h00, 8'h12, 8'h12, 8'ha5);
    run_op(CFL_OP_CCF, 8'h33, 8'h00, 8'h01, 8'h00, 8'h01, 8'h33);
    run_op(CFL_OP_SCF, 8'h33, 8'h00, 8'h10, 8'h01, 8'h11, 8'h33);
    run_op(CFL_OP_NOP, 8'h21, 8'h00, 8'h55, 8'h55, 8'hd7, 8'h21);
    // The wide add carries out of bit 15; half carry is left unchecked.
    axi_write(ADDR_HL, 32'h00002000, rsp);
    axi_write(ADDR_DE, 32'h0000f000, rsp);
    run_op(CFL_OP_ADD16, 8'h44, 8'h00, 8'h00, 8'h01, 8'h01, 8'h44);
    axi_read(ADDR_HL, rd, rsp);
    check(rd, 32'h00001000);
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end

endmodule
